/* mprb_bank.sv */
// Overview of operation
// - Raw 12-bit reading of each of eight analog inputs is readable.
// - Bus voltage compared with writable undervoltage threshold, reset 15.
// - Filter-write mask bits apply staged settings to selected inputs.
// - Bit 15 of filter-write register sets once settings are applied.
// - Readback index 1..8 loads that input's settings into staging.
// - Bit 15 of readback index sets after staging is loaded.
// - Confidence low 0..4094 reset 0, high 1..4095 reset 4095.
// - Slope limit 2..4095, reset 4095.
// - Filter weight 1..64 sixty-fourths of new sample, reset 64.
// - Per-input flags: conf failures high byte, slope failures low byte.
// - Encoder setup A packs five fields at fixed bit positions.
// - Encoder setup B holds prepare time; bit 8 enables Gray decode.
// - Routing mask low byte selects pulse outputs, high byte direction.
// - Mode 0 internal, 1 external, 2 both; mask only in 1 and 2.
// - Wait programmed milliseconds after each attempt before window check.
// - Four scope source selections, reset to zero.
// - Four run currents 0..1533, reset 511.
// - Attempt count up to 100; zero disables AutoCorrection.
`timescale 1ns/100ps
module mprb_bank #(
  parameter int SAMPLE_DIV = 125,
  parameter int MS_CYC = mprb_pkg::MS_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [mprb_pkg::N_AIN*12-1:0] analog_raw_i,
  input wire logic [11:0] supply_voltage_i,
  input wire logic [3:0] encoder_resolution_i,
  input wire logic [31:0] encoder_pos_i,
  input wire logic step_pulse_i,
  input wire logic step_dir_i,
  input wire logic ac_start_i,
  input wire logic ac_attempt_done_i,
  input wire logic in_window_i,
  output logic undervoltage_o,
  output logic [mprb_pkg::N_VEL*32-1:0] velocity_table_o,
  output logic [mprb_pkg::N_ACC*32-1:0] acceleration_table_o,
  output logic [mprb_pkg::N_CUR*11-1:0] run_current_table_o,
  output logic [31:0] serial_encoder_setup_a_o,
  output logic [7:0] ssi_prepare_time_o,
  output logic [31:0] encoder_pos_o,
  output logic [7:0] step_out_o,
  output logic step_internal_o,
  output logic [mprb_pkg::N_SCOPE*32-1:0] scope_source_select_o,
  output logic ac_attempt_o,
  output logic ac_busy_o,
  output logic ac_ok_o
);
  import mprb_pkg::*;

  // Clamp a written value into its accepted range
  function automatic logic [31:0] clampw(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
    clampw = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Two-flop synchronisers for the analog and supply voltage pin inputs
  logic [N_AIN*12-1:0] ain_s1_reg, ain_reg;
  logic [11:0] bus_s1_reg, bus_reg;
  always_ff @(posedge sys_clk_i) begin
    ain_s1_reg <= analog_raw_i;
    ain_reg <= ain_s1_reg;
    bus_s1_reg <= supply_voltage_i;
    bus_reg <= bus_s1_reg;
  end

  // AHB-Lite address phase capture; reads take one wait state so data leaves a flop
  logic dp_wr_reg, dp_rd_reg, rd_wait_reg;
  logic [7:0] dp_idx_reg;
  logic [31:0] hrdata_reg, rd_mux;
  wire take = hsel_i && htrans_i[1] && hready_i;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_idx_reg <= 8'h00;
    end else begin
      if (hready_i) begin
        dp_wr_reg <= take && hwrite_i;
        dp_rd_reg <= take && !hwrite_i;
        dp_idx_reg <= haddr_i[9:2];
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_wait_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      rd_wait_reg <= dp_rd_reg && !rd_wait_reg;
      if (dp_rd_reg && !rd_wait_reg) hrdata_reg <= rd_mux;
    end
  end
  assign hreadyout_o = !(dp_rd_reg && !rd_wait_reg);
  assign hrdata_o = hrdata_reg;
  assign hresp_o = 1'b0;
  wire wr = dp_wr_reg;
  wire [31:0] wd = hwdata_i;
  wire [7:0] idx = dp_idx_reg;

  // Motion tables
  logic [31:0] vel_reg [N_VEL];
  logic [31:0] acc_reg [N_ACC];
  logic [10:0] cur_reg [N_CUR];
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_VEL; i++) vel_reg[i] <= 32'h0000_0000;
      for (int i = 0; i < N_ACC; i++) acc_reg[i] <= 32'h0000_0000;
      for (int i = 0; i < N_CUR; i++) cur_reg[i] <= CUR_RST;
    end else if (wr) begin
      for (int i = 0; i < N_VEL; i++) if (idx == IDX_VEL + 8'(i)) vel_reg[i] <= wd;
      for (int i = 0; i < N_ACC; i++) if (idx == IDX_ACC + 8'(i)) acc_reg[i] <= wd;
      for (int i = 0; i < N_CUR; i++)
        if (idx == IDX_CUR + 8'(i)) cur_reg[i] <= 11'(clampw(wd, 32'h0, CUR_MAX));
    end
  end

  // Single configuration registers
  logic [11:0] uvt_reg;
  logic [31:0] sea_reg;
  logic [8:0] seb_reg;
  logic [15:0] rout_reg;
  logic [1:0] osel_reg;
  logic [14:0] wait_reg;
  logic [6:0] att_reg;
  logic [31:0] scope_reg [N_SCOPE];
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      uvt_reg <= UVT_RST;
      sea_reg <= 32'h0000_0000;
      seb_reg <= 9'h000;
      rout_reg <= 16'h0000;
      osel_reg <= MPRB_MODE_INT;
      wait_reg <= 15'h0000;
      att_reg <= 7'h00;
      for (int i = 0; i < N_SCOPE; i++) scope_reg[i] <= 32'h0000_0000;
    end else if (wr) begin
      if (idx == IDX_UVT) uvt_reg <= wd[11:0];
      if (idx == IDX_SEA) sea_reg <= wd;
      if (idx == IDX_SEB) seb_reg <= wd[8:0];
      if (idx == IDX_ROUT) rout_reg <= wd[15:0];
      if (idx == IDX_OSEL) osel_reg <= 2'(clampw(wd, 32'h0, MODE_MAX));
      if (idx == IDX_WAIT) wait_reg <= 15'(clampw(wd, 32'h0, WAIT_MAX));
      if (idx == IDX_ATT) att_reg <= 7'(clampw(wd, 32'h0, ATT_MAX));
      for (int i = 0; i < N_SCOPE; i++)
        if (idx == IDX_SCOPE + 8'(i)) scope_reg[i] <= wd;
    end
  end

  // Filter apply and readback handshakes; completion set one cycle after the write
  logic [7:0] fac_mask_reg, fri_idx_reg;
  logic fac_go_reg, fac_done_reg, fri_go_reg, fri_done_reg;
  wire fri_ok = (fri_idx_reg >= 8'h01) && (fri_idx_reg <= 8'(N_AIN));
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fac_mask_reg <= 8'h00;
      fac_go_reg <= 1'b0;
      fac_done_reg <= 1'b0;
      fri_idx_reg <= 8'h00;
      fri_go_reg <= 1'b0;
      fri_done_reg <= 1'b0;
    end else begin
      fac_go_reg <= wr && (idx == IDX_FAC);
      fri_go_reg <= wr && (idx == IDX_FRI);
      if (wr && idx == IDX_FAC) begin
        fac_mask_reg <= wd[7:0];
        fac_done_reg <= 1'b0;
      end else if (fac_go_reg) begin
        fac_done_reg <= 1'b1;
      end
      if (wr && idx == IDX_FRI) begin
        fri_idx_reg <= wd[7:0];
        fri_done_reg <= 1'b0;
      end else if (fri_go_reg && fri_ok) begin
        fri_done_reg <= 1'b1;
      end
    end
  end

  // Staged settings; a bus write in the load cycle wins as the newer intent
  logic [11:0] clo_reg, chi_reg, slp_reg;
  logic [6:0] fwt_reg;
  logic [11:0] cmin_reg [N_AIN];
  logic [11:0] cmax_reg [N_AIN];
  logic [11:0] slim_reg [N_AIN];
  logic [6:0] wgt_reg [N_AIN];
  wire [2:0] rb = 3'(fri_idx_reg - 8'h01);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clo_reg <= CLO_RST;
      chi_reg <= CHI_RST;
      slp_reg <= SLP_RST;
      fwt_reg <= FWT_RST;
    end else begin
      if (fri_go_reg && fri_ok) begin
        clo_reg <= cmin_reg[rb];
        chi_reg <= cmax_reg[rb];
        slp_reg <= slim_reg[rb];
        fwt_reg <= wgt_reg[rb];
      end
      if (wr && idx == IDX_CLO) clo_reg <= 12'(clampw(wd, 32'h0, CLO_MAX));
      if (wr && idx == IDX_CHI) chi_reg <= 12'(clampw(wd, CHI_MIN, ADC_MAX));
      if (wr && idx == IDX_SLP) slp_reg <= 12'(clampw(wd, SLP_MIN, ADC_MAX));
      if (wr && idx == IDX_FWT) fwt_reg <= 7'(clampw(wd, FWT_MIN, FWT_MAX));
    end
  end

  // Sample tick and shared quality window counter
  logic [15:0] div_reg;
  logic [3:0] win_reg;
  wire tick = (div_reg == 16'(SAMPLE_DIV - 1));
  wire win_end = tick && (win_reg == 4'(WIN_LEN - 1));
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_reg <= 16'h0000;
      win_reg <= 4'h0;
    end else begin
      div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
      if (tick) win_reg <= win_reg + 4'h1;
    end
  end

  // Per-input filter, limits and quality flags
  logic [11:0] filt_val [N_AIN];
  logic [15:0] flags;
  genvar g;
  generate
    for (g = 0; g < N_AIN; g++) begin : g_ain
      logic [17:0] acc_q;
      logic [11:0] prev_q;
      logic [4:0] nconf_q, nslp_q;
      logic fconf_q, fslp_q;
      wire [11:0] raw = ain_reg[g*12 +: 12];
      wire signed [18:0] diff = $signed({1'b0, raw, 6'h00}) - $signed({1'b0, acc_q});
      wire signed [26:0] prod = diff * $signed({1'b0, wgt_reg[g]});
      wire [12:0] dv = (raw > prev_q) ? 13'(raw - prev_q) : 13'(prev_q - raw);
      wire bad_c = (raw < cmin_reg[g]) || (raw > cmax_reg[g]);
      wire bad_s = dv > {1'b0, slim_reg[g]};
      // Apply staged values to masked inputs
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          cmin_reg[g] <= CLO_RST;
          cmax_reg[g] <= CHI_RST;
          slim_reg[g] <= SLP_RST;
          wgt_reg[g] <= FWT_RST;
        end else if (fac_go_reg && fac_mask_reg[g]) begin
          cmin_reg[g] <= clo_reg;
          cmax_reg[g] <= chi_reg;
          slim_reg[g] <= slp_reg;
          wgt_reg[g] <= fwt_reg;
        end
      end
      // Weighted update keeps six fraction bits to avoid creeping bias
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          acc_q <= 18'h00000;
          prev_q <= 12'h000;
        end else if (tick) begin
          acc_q <= 18'($signed({1'b0, acc_q}) + (prod >>> FRAC));
          prev_q <= raw;
        end
      end
      // Count failures per window; flag when half or more failed
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          nconf_q <= 5'h00;
          nslp_q <= 5'h00;
          fconf_q <= 1'b0;
          fslp_q <= 1'b0;
        end else if (tick) begin
          if (win_end) begin
            fconf_q <= (nconf_q + 5'(bad_c)) >= WIN_HALF;
            fslp_q <= (nslp_q + 5'(bad_s)) >= WIN_HALF;
            nconf_q <= 5'h00;
            nslp_q <= 5'h00;
          end else begin
            nconf_q <= nconf_q + 5'(bad_c);
            nslp_q <= nslp_q + 5'(bad_s);
          end
        end
      end
      assign filt_val[g] = acc_q[FRAC +: 12];
      assign flags[CONF_LSB + g] = fconf_q;
      assign flags[g] = fslp_q;
    end
  endgenerate

  // Undervoltage compare and step routing, both registered
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      undervoltage_o <= 1'b0;
      step_out_o <= 8'h00;
      step_internal_o <= 1'b1;
    end else begin
      undervoltage_o <= bus_reg < uvt_reg;
      step_internal_o <= (osel_reg == MPRB_MODE_INT) || (osel_reg == MPRB_MODE_BOTH);
      if (osel_reg == MPRB_MODE_EXT || osel_reg == MPRB_MODE_BOTH)
        step_out_o <= ({8{step_pulse_i}} & rout_reg[7:0]) |
                      ({8{step_dir_i}} & rout_reg[15:8]);
      else
        step_out_o <= 8'h00;
    end
  end

  // Gray to binary decode of the received position
  logic [31:0] gbin;
  assign gbin[31] = encoder_pos_i[31];
  generate
    for (g = 0; g < 31; g++) begin : g_gray
      assign gbin[g] = gbin[g + 1] ^ encoder_pos_i[g];
    end
  endgenerate
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) encoder_pos_o <= 32'h0000_0000;
    else encoder_pos_o <= seb_reg[GRAY_BIT] ? gbin : encoder_pos_i;
  end

  // AutoCorrection sequencer: attempt, settle, check window
  mprb_ac_t ac_reg;
  logic [6:0] tries_reg;
  logic [14:0] ms_left_reg;
  logic [31:0] cyc_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ac_reg <= MPRB_AC_IDLE;
      tries_reg <= 7'h00;
      ms_left_reg <= 15'h0000;
      cyc_reg <= 32'h0000_0000;
      ac_ok_o <= 1'b0;
    end else begin
      case (ac_reg)
        MPRB_AC_IDLE: begin
          if (ac_start_i && att_reg != 7'h00) begin
            ac_reg <= MPRB_AC_TRY;
            tries_reg <= 7'h00;
            ac_ok_o <= 1'b0;
          end
        end
        MPRB_AC_TRY: begin
          if (ac_attempt_done_i) begin
            ac_reg <= MPRB_AC_SETTLE;
            tries_reg <= tries_reg + 7'h01;
            ms_left_reg <= wait_reg;
            cyc_reg <= 32'h0000_0000;
          end
        end
        MPRB_AC_SETTLE: begin
          if (ms_left_reg == 15'h0000) begin
            ac_reg <= MPRB_AC_CHECK;
          end else if (cyc_reg == 32'(MS_CYC - 1)) begin
            cyc_reg <= 32'h0000_0000;
            ms_left_reg <= ms_left_reg - 15'h0001;
          end else begin
            cyc_reg <= cyc_reg + 32'h0000_0001;
          end
        end
        MPRB_AC_CHECK: begin
          if (in_window_i) begin
            ac_reg <= MPRB_AC_IDLE;
            ac_ok_o <= 1'b1;
          end else if (tries_reg >= att_reg) begin
            ac_reg <= MPRB_AC_IDLE;
          end else begin
            ac_reg <= MPRB_AC_TRY;
          end
        end
        default: ac_reg <= MPRB_AC_IDLE;
      endcase
    end
  end
  assign ac_attempt_o = (ac_reg == MPRB_AC_TRY);
  assign ac_busy_o = (ac_reg != MPRB_AC_IDLE);

  // Read decode; unmapped indexes read zero
  logic [7:0] off;
  always_comb begin
    rd_mux = 32'h0000_0000;
    off = 8'h00;
    if (idx >= IDX_VEL && idx < IDX_ACC) begin
      off = idx - IDX_VEL;
      rd_mux = vel_reg[off[2:0]];
    end else if (idx >= IDX_ACC && idx < IDX_CUR) begin
      off = idx - IDX_ACC;
      rd_mux = acc_reg[off[1:0]];
    end else if (idx >= IDX_CUR && idx < IDX_FILT) begin
      off = idx - IDX_CUR;
      rd_mux = {21'h0, cur_reg[off[1:0]]};
    end else if (idx >= IDX_FILT && idx < IDX_RAW) begin
      off = idx - IDX_FILT;
      rd_mux = {20'h0, filt_val[off[2:0]]};
    end else if (idx >= IDX_RAW && idx < IDX_BUS) begin
      off = idx - IDX_RAW;
      rd_mux = {20'h0, ain_reg[off[2:0]*12 +: 12]};
    end else if (idx >= IDX_SCOPE && idx < IDX_ATT) begin
      off = idx - IDX_SCOPE;
      rd_mux = scope_reg[off[1:0]];
    end else begin
      case (idx)
        IDX_BUS: rd_mux = {20'h0, bus_reg};
        IDX_UVT: rd_mux = {20'h0, uvt_reg};
        IDX_ENC: rd_mux = {28'h0, encoder_resolution_i};
        IDX_FAC: rd_mux = {16'h0, fac_done_reg, 7'h00, fac_mask_reg};
        IDX_FRI: rd_mux = {16'h0, fri_done_reg, 7'h00, fri_idx_reg};
        IDX_CLO: rd_mux = {20'h0, clo_reg};
        IDX_CHI: rd_mux = {20'h0, chi_reg};
        IDX_SLP: rd_mux = {20'h0, slp_reg};
        IDX_FWT: rd_mux = {25'h0, fwt_reg};
        IDX_FLG: rd_mux = {16'h0, flags};
        IDX_SEA: rd_mux = sea_reg;
        IDX_ROUT: rd_mux = {16'h0, rout_reg};
        IDX_OSEL: rd_mux = {30'h0, osel_reg};
        IDX_WAIT: rd_mux = {17'h0, wait_reg};
        IDX_SEB: rd_mux = {23'h0, seb_reg};
        IDX_ATT: rd_mux = {25'h0, att_reg};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Configuration outputs straight from their registers
  generate
    for (g = 0; g < N_VEL; g++) begin : g_vo
      assign velocity_table_o[g*32 +: 32] = vel_reg[g];
    end
    for (g = 0; g < N_ACC; g++) begin : g_ao
      assign acceleration_table_o[g*32 +: 32] = acc_reg[g];
      assign run_current_table_o[g*11 +: 11] = cur_reg[g];
      assign scope_source_select_o[g*32 +: 32] = scope_reg[g];
    end
  endgenerate
  assign serial_encoder_setup_a_o = sea_reg;
  assign ssi_prepare_time_o = seb_reg[7:0];
endmodule // mprb_bank

/* mprb_bank_asserts.sv */
`timescale 1ns/100ps
// Pin-level checks on bus timing, step routing and AutoCorrection sequencing
module mprb_bank_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic step_pulse_i,
  input wire logic step_dir_i,
  input wire logic [7:0] step_out_o,
  input wire logic ac_start_i,
  input wire logic ac_attempt_done_i,
  input wire logic ac_attempt_o,
  input wire logic ac_busy_o,
  input wire logic ac_ok_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Reads cost one wait state, writes none
  a_read_wait: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
    |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait state wrong");
  a_write_nowait: assert property (hsel_i && htrans_i[1] && hready_i && hwrite_i
    |=> hreadyout_o) else $error("write stalled");
  a_resp_okay: assert property (hresp_o == 1'b0) else $error("error response seen");
  // Outputs only carry what the step sources drove
  a_route_source: assert property (step_out_o != 8'h00 |->
    $past(step_pulse_i) || $past(step_dir_i)) else $error("step output without source");
  // An attempt only runs inside a busy run
  a_attempt_busy: assert property (ac_attempt_o |-> ac_busy_o)
    else $error("attempt outside run");
  a_run_start: assert property ($rose(ac_busy_o) |-> $past(ac_start_i))
    else $error("run began unrequested");
  a_idle_stays: assert property (!ac_busy_o && !ac_start_i |=> !ac_busy_o)
    else $error("idle left without start");
  // A finished attempt must give way to the settling wait
  a_attempt_ends: assert property (ac_attempt_o && ac_attempt_done_i
    |=> !ac_attempt_o) else $error("attempt did not end");
  a_ok_held: assert property (!ac_busy_o && !$past(ac_busy_o) |-> $stable(ac_ok_o))
    else $error("result changed while idle");
  c_ok: cover property (ac_ok_o && !ac_busy_o);
  c_done: cover property (ac_attempt_o && ac_attempt_done_i);
  c_route: cover property (step_out_o == 8'h03);
endmodule // mprb_bank_asserts

bind mprb_bank mprb_bank_asserts mprb_bank_asserts_i (.sys_clk_i, .rst_i, .hsel_i,
  .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .step_pulse_i, .step_dir_i,
  .step_out_o, .ac_start_i, .ac_attempt_done_i, .ac_attempt_o, .ac_busy_o, .ac_ok_o);

/* mprb_bank_test.sv */
`timescale 1ns/100ps
module mprb_bank_test;
  import mprb_pkg::*;
  logic clk = 1'b0, rst, hsel, hwrite, hrdy, hresp, pul, dir, acs, acd, inw, uv;
  logic sint, att, busy, ok;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, pos, seta, epos;
  logic [95:0] raw;
  logic [11:0] sv;
  logic [7:0] prep, sout;
  logic [255:0] vel;
  logic [127:0] acco, scp;
  logic [43:0] curo;
  int bad_count = 0;
  int compares = 0;
  // Block under test with short settle and sample periods
  mprb_bank #(.SAMPLE_DIV(2), .MS_CYC(10)) mprb_bank_i (.sys_clk_i(clk), .rst_i(rst),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .analog_raw_i(raw), .supply_voltage_i(sv),
    .encoder_resolution_i(4'h3), .encoder_pos_i(pos), .step_pulse_i(pul),
    .step_dir_i(dir), .ac_start_i(acs), .ac_attempt_done_i(acd), .in_window_i(inw),
    .undervoltage_o(uv), .velocity_table_o(vel), .acceleration_table_o(acco),
    .run_current_table_o(curo), .serial_encoder_setup_a_o(seta), .ssi_prepare_time_o(prep),
    .encoder_pos_o(epos), .step_out_o(sout), .step_internal_o(sint),
    .scope_source_select_o(scp), .ac_attempt_o(att), .ac_busy_o(busy), .ac_ok_o(ok));
  mprb_host mprb_host_i (.sys_clk_i(clk), .hready_i(hrdy), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata));
  always #4 clk = ~clk;
  task automatic final_report;
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    mprb_host_i.xfer(1'b1, i, d, r);
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] r;
    mprb_host_i.xfer(1'b0, i, 32'h0, r);
    chk(r, e);
  endtask
  // Write then read back, expecting a clamp where the value is out of range
  task automatic wc(input logic [7:0] i, input logic [31:0] d, input logic [31:0] e);
    wr(i, d);
    rc(i, e);
  endtask
  task automatic t_reset;
    rc(IDX_CUR, 32'h1ff);
    rc(IDX_CUR + 8'h3, 32'h1ff);
    rc(IDX_UVT, 32'hf);
    rc(IDX_CLO, 32'h0);
    rc(IDX_CHI, 32'hfff);
    rc(IDX_SLP, 32'hfff);
    rc(IDX_FWT, 32'h40);
    rc(IDX_SCOPE + 8'h3, 32'h0);
    rc(IDX_FLG, 32'h0);
    rc(IDX_FAC, 32'h0);
    rc(IDX_FRI, 32'h0);
    wc(8'h75, 32'h5a5a, 32'h0);
  endtask
  task automatic t_ranges;
    wc(IDX_CUR, 32'h5fd, 32'h5fd);
    wc(IDX_CUR + 8'h1, 32'h5fe, 32'h5fd);
    wc(IDX_CLO, 32'hfff, 32'hffe);
    wc(IDX_CHI, 32'h0, 32'h1);
    wc(IDX_SLP, 32'h1, 32'h2);
    wc(IDX_FWT, 32'h0, 32'h1);
    wc(IDX_FWT, 32'h41, 32'h40);
    wc(IDX_WAIT, 32'h7fa5, 32'h7fa4);
    wc(IDX_ATT, 32'h65, 32'h64);
    wc(IDX_UVT, 32'hfff, 32'hfff);
    wc(IDX_SCOPE + 8'h2, 32'h61, 32'h61);
    wr(IDX_VEL + 8'h7, 32'h12345678);
    wr(IDX_ACC + 8'h3, 32'h7a120);
    @(posedge clk);
    chk(vel[255:224], 32'h12345678);
    chk(acco[127:96], 32'h7a120);
    chk({21'h0, curo[21:11]}, 32'h5fd);
    chk(scp[95:64], 32'h61);
    rc(IDX_VEL + 8'h7, 32'h12345678);
  endtask
  // Raw readback per input, then the undervoltage compare at its edge
  task automatic t_raw;
    logic [95:0] v;
    for (int n = 0; n < 8; n++) v[12*n +: 12] = 12'(n * 12'h1f1);
    raw <= v;
    wr(IDX_UVT, 32'hf);
    sv <= 12'h00e;
    repeat (4) @(posedge clk);
    for (int n = 0; n < 8; n++) rc(IDX_RAW + 8'(n), {20'h0, v[12*n +: 12]});
    chk({31'h0, uv}, 32'h1);
    rc(IDX_BUS, 32'he);
    rc(IDX_ENC, 32'h3);
    sv <= 12'h00f;
    repeat (4) @(posedge clk);
    chk({31'h0, uv}, 32'h0);
  endtask
  task automatic t_filter;
    wr(IDX_CLO, 32'h5);
    wr(IDX_CHI, 32'h100);
    wr(IDX_SLP, 32'h7);
    wr(IDX_FWT, 32'h3);
    wr(IDX_FAC, 32'h1);
    repeat (2) @(posedge clk);
    rc(IDX_FAC, 32'h8001);
    wr(IDX_FRI, 32'h2);
    repeat (2) @(posedge clk);
    rc(IDX_CLO, 32'h0);
    rc(IDX_SLP, 32'hfff);
    wr(IDX_FRI, 32'h1);
    repeat (2) @(posedge clk);
    rc(IDX_FRI, 32'h8001);
    rc(IDX_CHI, 32'h100);
    rc(IDX_FWT, 32'h3);
    wc(IDX_FRI, 32'h9, 32'h9);
    repeat (80) @(posedge clk);
    rc(IDX_FLG, 32'h100);
    rc(IDX_FILT + 8'h1, 32'h1f1);
  endtask
  task automatic t_step;
    wr(IDX_ROUT, 32'h0201);
    wr(IDX_OSEL, 32'h1);
    pul <= 1'b1;
    repeat (3) @(posedge clk);
    chk({24'h0, sout}, 32'h1);
    chk({31'h0, sint}, 32'h0);
    dir <= 1'b1;
    wr(IDX_OSEL, 32'h2);
    repeat (3) @(posedge clk);
    chk({23'h0, sint, sout}, 32'h103);
    wr(IDX_OSEL, 32'h0);
    repeat (3) @(posedge clk);
    chk({23'h0, sint, sout}, 32'h100);
  endtask
  task automatic t_enc;
    wr(IDX_SEA, 32'ha5c31e2f);
    wr(IDX_SEB, 32'h17b);
    pos <= 32'h6;
    repeat (3) @(posedge clk);
    chk(seta, 32'ha5c31e2f);
    chk({24'h0, prep}, 32'h7b);
    chk(epos, 32'h4);
    wr(IDX_SEB, 32'h07b);
    repeat (3) @(posedge clk);
    chk(epos, 32'h6);
  endtask
  task automatic pulse(input bit done);
    if (done) acd <= 1'b1;
    else acs <= 1'b1;
    @(posedge clk);
    acd <= 1'b0;
    acs <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Two attempts that miss, one that lands, then a disabled run
  task automatic t_ac;
    wr(IDX_WAIT, 32'h2);
    wr(IDX_ATT, 32'h2);
    pulse(1'b0);
    chk({30'h0, busy, att}, 32'h3);
    pulse(1'b1);
    repeat (14) @(posedge clk);
    chk({30'h0, busy, att}, 32'h2);
    repeat (10) @(posedge clk);
    chk({31'h0, att}, 32'h1);
    pulse(1'b1);
    repeat (30) @(posedge clk);
    chk({30'h0, busy, ok}, 32'h0);
    inw <= 1'b1;
    pulse(1'b0);
    pulse(1'b1);
    repeat (30) @(posedge clk);
    chk({30'h0, busy, ok}, 32'h1);
    wr(IDX_ATT, 32'h0);
    pulse(1'b0);
    chk({31'h0, busy}, 32'h0);
  endtask
  initial begin
    rst = 1'b1;
    raw = 96'h0;
    sv = 12'h0;
    pos = 32'h0;
    {pul, dir, acs, acd, inw} = 5'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_ranges;
    t_raw;
    t_filter;
    t_step;
    t_enc;
    t_ac;
    final_report;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule // mprb_bank_test

/* mprb_host.sv */
`timescale 1ns/100ps
// Host side of the register bus: single word transfers, waits on ready
module mprb_host (
  input wire logic sys_clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  initial begin
    hsel_o = 1'b1;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end
  // Called just after an edge; a hang is left to the bench watchdog
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    haddr_o <= {22'h000000, idx, 2'b00};
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    do @(posedge sys_clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'b00;
    hwdata_o <= wr ? wd : ~hwdata_o;
    do @(posedge sys_clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
    hwdata_o <= ~hwdata_o; // Stale data must not look valid
  endtask
endmodule // mprb_host

/* mprb_pkg.sv */
package mprb_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_VEL = 8'h41;
  localparam logic [7:0] IDX_ACC = 8'h49;
  localparam logic [7:0] IDX_CUR = 8'h4d;
  localparam logic [7:0] IDX_FILT = 8'h51;
  localparam logic [7:0] IDX_RAW = 8'h59;
  localparam logic [7:0] IDX_BUS = 8'h61;
  localparam logic [7:0] IDX_UVT = 8'h62;
  localparam logic [7:0] IDX_ENC = 8'h63;
  localparam logic [7:0] IDX_FAC = 8'h64;
  localparam logic [7:0] IDX_FRI = 8'h65;
  localparam logic [7:0] IDX_CLO = 8'h66;
  localparam logic [7:0] IDX_CHI = 8'h67;
  localparam logic [7:0] IDX_SLP = 8'h68;
  localparam logic [7:0] IDX_FWT = 8'h69;
  localparam logic [7:0] IDX_FLG = 8'h6a;
  localparam logic [7:0] IDX_SEA = 8'h6b;
  localparam logic [7:0] IDX_ROUT = 8'h6c;
  localparam logic [7:0] IDX_OSEL = 8'h6d;
  localparam logic [7:0] IDX_WAIT = 8'h6e;
  localparam logic [7:0] IDX_SEB = 8'h6f;
  localparam logic [7:0] IDX_SCOPE = 8'h70;
  localparam logic [7:0] IDX_ATT = 8'h74;
  // Table sizes
  localparam int N_VEL = 8;
  localparam int N_ACC = 4;
  localparam int N_CUR = 4;
  localparam int N_AIN = 8;
  localparam int N_SCOPE = 4;
  // Reset values and accepted ranges
  localparam logic [10:0] CUR_RST = 11'h1ff;
  localparam logic [31:0] CUR_MAX = 32'h5fd;
  localparam logic [11:0] UVT_RST = 12'h00f;
  localparam logic [11:0] CLO_RST = 12'h000;
  localparam logic [11:0] CHI_RST = 12'hfff;
  localparam logic [11:0] SLP_RST = 12'hfff;
  localparam logic [6:0] FWT_RST = 7'h40;
  localparam logic [31:0] CLO_MAX = 32'hffe;
  localparam logic [31:0] CHI_MIN = 32'h001;
  localparam logic [31:0] ADC_MAX = 32'hfff;
  localparam logic [31:0] SLP_MIN = 32'h002;
  localparam logic [31:0] FWT_MIN = 32'h001;
  localparam logic [31:0] FWT_MAX = 32'h040;
  localparam logic [31:0] ATT_MAX = 32'h064;
  localparam logic [31:0] WAIT_MAX = 32'h7fa4;
  localparam logic [31:0] MODE_MAX = 32'h002;
  // Field positions
  localparam int DONE_BIT = 15;
  localparam int CONF_LSB = 8;
  localparam int GRAY_BIT = 8;
  localparam int FRAC = 6;
  // Quality window: flag when at least half of WIN_LEN samples fail
  localparam int WIN_LEN = 16;
  localparam logic [4:0] WIN_HALF = 5'h08;
  // Settling time base
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 8;
  localparam int MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    MPRB_MODE_INT = 2'b00,
    MPRB_MODE_EXT = 2'b01,
    MPRB_MODE_BOTH = 2'b10
  } mprb_pdmode_t;
  typedef enum logic [1:0] {
    MPRB_AC_IDLE = 2'b00,
    MPRB_AC_TRY = 2'b01,
    MPRB_AC_SETTLE = 2'b10,
    MPRB_AC_CHECK = 2'b11
  } mprb_ac_t;
endpackage
